// ===== src/bsp_pkg.sv
// Purpose: shared constants and types of the boot ROM serial port
// Assumes: link clock of LINK_CLK_MHZ feeds the serial engine
// Notes: half periods are counted in link clock cycles
package bsp_pkg;
    // ****************************************
    // rates and timing
    // ****************************************
    localparam int BSP_LINK_CLK_MHZ = 120;
    localparam int BSP_RATE_SLOW_MHZ = 30;
    localparam int BSP_RATE_FAST_MHZ = 60;
    localparam int BSP_HALF_SLOW = BSP_LINK_CLK_MHZ / (2 * BSP_RATE_SLOW_MHZ);
    localparam int BSP_HALF_FAST = BSP_LINK_CLK_MHZ / (2 * BSP_RATE_FAST_MHZ);
    localparam int BSP_RESET_MIN_NS = 1000;
    localparam int BSP_SYS_CLK_MHZ = 100;
    localparam int BSP_RESET_MIN_CYC = (BSP_RESET_MIN_NS * BSP_SYS_CLK_MHZ + 999) / 1000;
    localparam logic [1:0] BSP_STRAP_SETTLE = 2'h3;
    localparam int BSP_SPI_BITS = 8;
    localparam int BSP_EEP_BITS = 9;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] BSP_BYTE_RESET = 8'h00;
    localparam logic BSP_STRAP_RESET = 1'b0;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {BSP_CMD_BYTE, BSP_CMD_START, BSP_CMD_STOP, BSP_CMD_DESELECT} bsp_cmd_e;

    typedef struct packed {
        bsp_cmd_e cmd;
        logic [7:0] data;
    } bsp_req_s;

    typedef struct packed {
        logic [7:0] data;
        logic ack_n;
    } bsp_rsp_s;

    typedef struct packed {
        logic eeprom_mode;
        logic suspend;
        logic power_down;
        logic port_enable;
        logic rate_strap;
        logic strap_done;
    } bsp_ctl_s;
endpackage

// ===== src/bsp_shifter.sv
// Purpose: bit engine for serial ROM bytes and two-wire conditions
// Assumes: runs on the link clock; start_i is a one cycle pulse
// Notes: spi mode 0, msb first; two-wire bytes carry a ninth ack bit
`timescale 1ns/100ps
module bsp_shifter
    import bsp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire bsp_pkg::bsp_req_s req_i,
    input wire logic eeprom_i,
    input wire logic [3:0] half_i,
    input wire logic sdi_i,
    output logic done_o,
    output bsp_pkg::bsp_rsp_s rsp_o,
    output logic sclk_o,
    output logic sdo_o
);
    typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_COND} bsp_state_e;
    bsp_state_e state;
    logic [3:0] tick;
    logic [3:0] nbit;
    logic [1:0] step;
    logic [8:0] shreg;
    logic is_start;
    logic half_done;

    assign half_done = (tick == half_i - 4'h1);

    // pins lag the engine by one flop, so data is taken as the pad clock rises
    logic [8:0] shreg_in;
    assign shreg_in = (tick == 4'h0) ? {shreg[7:0], sdi_i} : shreg;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state <= ST_IDLE;
            tick <= 4'h0;
            nbit <= 4'h0;
            step <= 2'h0;
            shreg <= 9'h000;
            is_start <= 1'b0;
            done_o <= 1'b0;
            rsp_o <= '0;
            sclk_o <= 1'b0;
            sdo_o <= 1'b1;
        end
        else
        begin
            done_o <= 1'b0;
            tick <= (state == ST_IDLE || half_done) ? 4'h0 : tick + 4'h1;
            case (state)
                ST_IDLE:
                begin
                    if (start_i && req_i.cmd == BSP_CMD_BYTE)
                    begin
                        // ack slot released so the eeprom can pull it low
                        shreg <= {req_i.data, 1'b1};
                        nbit <= eeprom_i ? 4'(BSP_EEP_BITS) : 4'(BSP_SPI_BITS);
                        sclk_o <= 1'b0;
                        sdo_o <= req_i.data[7];
                        state <= ST_LOW;
                    end
                    else if (start_i && eeprom_i && req_i.cmd != BSP_CMD_DESELECT)
                    begin
                        is_start <= (req_i.cmd == BSP_CMD_START);
                        step <= 2'h0;
                        sdo_o <= (req_i.cmd == BSP_CMD_START);
                        sclk_o <= (req_i.cmd == BSP_CMD_START);
                        state <= ST_COND;
                    end
                    else if (start_i)
                    begin
                        done_o <= 1'b1;
                    end
                end
                ST_LOW:
                begin
                    if (half_done)
                    begin
                        sclk_o <= 1'b1;
                        nbit <= nbit - 4'h1;
                        state <= ST_HIGH;
                    end
                end
                ST_HIGH:
                begin
                    shreg <= shreg_in;
                    if (half_done)
                    begin
                        sclk_o <= 1'b0;
                        sdo_o <= shreg_in[8];
                        if (nbit == 4'h0)
                        begin
                            done_o <= 1'b1;
                            sdo_o <= eeprom_i ? 1'b0 : shreg_in[8];
                            rsp_o.data <= eeprom_i ? shreg_in[8:1] : shreg_in[7:0];
                            rsp_o.ack_n <= eeprom_i ? shreg_in[0] : 1'b0;
                            state <= ST_IDLE;
                        end
                        else
                        begin
                            state <= ST_LOW;
                        end
                    end
                end
                ST_COND:
                begin
                    if (half_done)
                    begin
                        step <= step + 2'h1;
                        if (step == 2'h0)
                        begin
                            sdo_o <= is_start ? 1'b0 : sdo_o;
                            sclk_o <= is_start ? sclk_o : 1'b1;
                        end
                        else
                        begin
                            sclk_o <= is_start ? 1'b0 : sclk_o;
                            sdo_o <= is_start ? sdo_o : 1'b1;
                            done_o <= 1'b1;
                            state <= ST_IDLE;
                        end
                    end
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// ===== src/bsp_sync.sv
// Purpose: two flop level synchroniser
// Assumes: each bit is an independent, slowly changing level
// Notes: first stage feeds only the second
`timescale 1ns/100ps
module bsp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            meta <= '0;
            q_o <= '0;
        end
        else
        begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule

// ===== src/bsp_top.sv
// Purpose: boot ROM serial port pins, strap capture and request crossing
// Assumes: link_clk_i runs freely; requests come from sys_clk_i logic
// Notes: output enables are low while the pin is driven
`timescale 1ns/100ps
module bsp_top
    import bsp_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic link_clk_i,
    input wire logic req_valid_i,
    input wire bsp_pkg::bsp_req_s req_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output bsp_pkg::bsp_rsp_s rsp_o,
    input wire logic eeprom_mode_i,
    input wire logic suspend_i,
    input wire logic power_down_i,
    input wire logic port_enable_i,
    output logic rom_rate_strap_o,
    output logic strap_valid_o,
    output logic rom_select_n_o,
    output logic eeprom_clock_line_o,
    output logic eeprom_clock_line_oe_n_o,
    output logic eeprom_data_line_o,
    output logic eeprom_data_line_oe_n_o,
    output logic eeprom_data_line_pd_en_o,
    input wire logic eeprom_data_line_i,
    input wire logic rom_data_in_i
);
    // ****************************************
    // core domain: strap capture
    // ****************************************
    logic data_pin_sync;
    logic [1:0] settle;
    logic rom_rate_strap;
    logic strap_done;

    bsp_sync #(.WIDTH(1)) u_pin_sync (
        .clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .d_i(eeprom_data_line_i),
        .q_o(data_pin_sync)
    );

    // pin still floats with pull-down here, so the synced level is the strap
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            settle <= 2'h0;
            rom_rate_strap <= BSP_STRAP_RESET;
            strap_done <= 1'b0;
        end
        else if (!strap_done)
        begin
            settle <= settle + 2'h1;
            if (settle == BSP_STRAP_SETTLE)
            begin
                rom_rate_strap <= data_pin_sync;
                strap_done <= 1'b1;
            end
        end
        // strap frozen once caught
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rom_rate_strap_o <= BSP_STRAP_RESET;
            strap_valid_o <= 1'b0;
        end
        else
        begin
            rom_rate_strap_o <= rom_rate_strap;
            strap_valid_o <= strap_done;
        end
    end

    // ****************************************
    // core domain: request handshake
    // ****************************************
    bsp_req_s req_hold;
    logic req_tgl;
    logic busy;
    logic ack_sync;
    logic ack_seen;
    bsp_rsp_s link_rsp;
    logic link_ack_tgl;

    bsp_sync #(.WIDTH(1)) u_ack_sync (
        .clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .d_i(link_ack_tgl),
        .q_o(ack_sync)
    );

    // request word stays still while busy, so the link may sample it freely
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            req_hold <= '{cmd: BSP_CMD_DESELECT, data: BSP_BYTE_RESET};
            req_tgl <= 1'b0;
            busy <= 1'b0;
            ack_seen <= 1'b0;
            req_ready_o <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_o <= '0;
        end
        else
        begin
            rsp_valid_o <= 1'b0;
            if (req_valid_i && req_ready_o)
            begin
                req_hold <= req_i;
                req_tgl <= ~req_tgl;
                busy <= 1'b1;
                req_ready_o <= 1'b0;
            end
            else if (busy && ack_sync != ack_seen)
            begin
                ack_seen <= ack_sync;
                busy <= 1'b0;
                rsp_valid_o <= 1'b1;
                rsp_o <= link_rsp;
                req_ready_o <= strap_done;
            end
            else
            begin
                req_ready_o <= strap_done && !busy;
            end
        end
    end

    // ****************************************
    // link domain: reset and crossings
    // ****************************************
    logic lrst_meta;
    logic lrstn;
    bsp_ctl_s ctl_core;
    bsp_ctl_s ctl;
    logic req_tgl_sync;
    logic req_seen;
    logic eng_start;
    logic eng_done;
    bsp_rsp_s eng_rsp;
    logic eng_sclk;
    logic eng_sdo;
    logic [3:0] half;

    // asserts at once, releases on the link clock
    always_ff @(posedge link_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            lrst_meta <= 1'b0;
            lrstn <= 1'b0;
        end
        else
        begin
            lrst_meta <= 1'b1;
            lrstn <= lrst_meta;
        end
    end

    assign ctl_core = '{eeprom_mode: eeprom_mode_i, suspend: suspend_i, power_down: power_down_i,
                        port_enable: port_enable_i, rate_strap: rom_rate_strap, strap_done: strap_done};

    // strap is loaded on the same core edge as strap_done, and neither changes after
    bsp_sync #(.WIDTH($bits(bsp_ctl_s))) u_ctl_sync (
        .clk_i(link_clk_i),
        .rstn_i(lrstn),
        .d_i(ctl_core),
        .q_o(ctl)
    );

    bsp_sync #(.WIDTH(1)) u_req_sync (
        .clk_i(link_clk_i),
        .rstn_i(lrstn),
        .d_i(req_tgl),
        .q_o(req_tgl_sync)
    );

    assign eng_start = (req_tgl_sync != req_seen);
    assign half = ctl.rate_strap ? 4'(BSP_HALF_FAST) : 4'(BSP_HALF_SLOW);

    always_ff @(posedge link_clk_i or negedge lrstn)
    begin
        if (!lrstn)
        begin
            req_seen <= 1'b0;
            link_ack_tgl <= 1'b0;
            link_rsp <= '0;
        end
        else
        begin
            req_seen <= req_tgl_sync;
            if (eng_done)
            begin
                link_rsp <= eng_rsp;
                link_ack_tgl <= ~link_ack_tgl;
            end
        end
    end

    // far side runs on our own serial clock, so its data is link-timed already;
    // a synchroniser here would shift every sampled bit late
    bsp_shifter u_shifter (
        .clk_i(link_clk_i),
        .rstn_i(lrstn),
        .start_i(eng_start),
        .req_i(req_hold),
        .eeprom_i(ctl.eeprom_mode),
        .half_i(half),
        .sdi_i(ctl.eeprom_mode ? eeprom_data_line_i : rom_data_in_i),
        .done_o(eng_done),
        .rsp_o(eng_rsp),
        .sclk_o(eng_sclk),
        .sdo_o(eng_sdo)
    );

    // ****************************************
    // link domain: pin drivers
    // ****************************************
    logic select_n;

    always_ff @(posedge link_clk_i or negedge lrstn)
    begin
        if (!lrstn)
        begin
            select_n <= 1'b1;
        end
        else if (eng_start && !ctl.eeprom_mode)
        begin
            if (req_hold.cmd == BSP_CMD_BYTE)
            begin
                select_n <= 1'b0;
            end
            else if (req_hold.cmd == BSP_CMD_DESELECT)
            begin
                select_n <= 1'b1;
            end
        end
    end

    always_ff @(posedge link_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rom_select_n_o <= 1'b1;
            eeprom_clock_line_o <= 1'b0;
            eeprom_clock_line_oe_n_o <= 1'b0;
            eeprom_data_line_o <= 1'b0;
            eeprom_data_line_oe_n_o <= 1'b1;
            eeprom_data_line_pd_en_o <= 1'b1;
        end
        else
        begin
            rom_select_n_o <= (ctl.port_enable && ctl.power_down) ? 1'b1 : select_n;
            eeprom_clock_line_o <= lrstn ? eng_sclk : 1'b0;
            eeprom_clock_line_oe_n_o <= 1'b0;
            if (!ctl.strap_done)
            begin
                // pin left to the strap until the core has caught it
                eeprom_data_line_o <= 1'b0;
                eeprom_data_line_oe_n_o <= 1'b1;
                eeprom_data_line_pd_en_o <= 1'b1;
            end
            else if (ctl.suspend)
            begin
                eeprom_data_line_o <= 1'b0;
                eeprom_data_line_oe_n_o <= ctl.rate_strap;
                eeprom_data_line_pd_en_o <= 1'b0;
            end
            else if (ctl.eeprom_mode)
            begin
                // open drain: only a low is driven
                eeprom_data_line_o <= 1'b0;
                eeprom_data_line_oe_n_o <= eng_sdo;
                eeprom_data_line_pd_en_o <= 1'b0;
            end
            else
            begin
                eeprom_data_line_o <= eng_sdo;
                eeprom_data_line_oe_n_o <= 1'b0;
                eeprom_data_line_pd_en_o <= 1'b0;
            end
        end
    end
endmodule

// ===== tb/bsp_checker.sv
// Purpose: pin and handshake checks of the boot ROM serial port
// Assumes: bound to bsp_top, sees only its ports
// Notes: pin checks sample on the link clock, the pull-down release check on the core clock
`timescale 1ns/100ps
module bsp_checker (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic link_clk_i,
    input wire logic req_valid_i,
    input wire logic req_ready_o,
    input wire logic eeprom_mode_i,
    input wire logic suspend_i,
    input wire logic power_down_i,
    input wire logic port_enable_i,
    input wire logic rom_rate_strap_o,
    input wire logic strap_valid_o,
    input wire logic rom_select_n_o,
    input wire logic eeprom_clock_line_o,
    input wire logic eeprom_clock_line_oe_n_o,
    input wire logic eeprom_data_line_o,
    input wire logic eeprom_data_line_oe_n_o,
    input wire logic eeprom_data_line_pd_en_o
);
    // ****************************************
    // assertions
    // ****************************************
    // reset is the cause here, so it cannot disable the check
    chk_reset_pins: assert property (@(posedge link_clk_i) !rstn_i |-> !eeprom_clock_line_o
        && eeprom_data_line_oe_n_o && eeprom_data_line_pd_en_o) else $error("pins wrong in reset");
    chk_strap_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        strap_valid_o |=> strap_valid_o && $stable(rom_rate_strap_o)) else $error("strap changed");
    chk_pd_release: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        $rose(strap_valid_o) |-> ##[0:12] !eeprom_data_line_pd_en_o) else $error("pull-down kept");
    chk_select_pwrdn: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
        (port_enable_i && power_down_i) [*4] |-> rom_select_n_o) else $error("select low in power down");
    chk_susp_float: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
        (strap_valid_o && rom_rate_strap_o && suspend_i) [*4] |-> eeprom_data_line_oe_n_o)
        else $error("pad driven in suspend");
    chk_susp_low: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
        (strap_valid_o && !rom_rate_strap_o && suspend_i) [*4] |-> !eeprom_data_line_oe_n_o
        && !eeprom_data_line_o) else $error("pad not low in suspend");
    chk_fast_clk: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
        $rose(eeprom_clock_line_o) && !eeprom_mode_i && rom_rate_strap_o |=> !eeprom_clock_line_o)
        else $error("fast high phase wrong");
    chk_slow_clk: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
        $rose(eeprom_clock_line_o) && !eeprom_mode_i && !rom_rate_strap_o |=> eeprom_clock_line_o
        ##1 !eeprom_clock_line_o) else $error("slow high phase wrong");
    chk_clk_driven: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
        !eeprom_clock_line_oe_n_o) else $error("clock pin released");
    chk_sdo_driven: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
        !rom_select_n_o && !suspend_i |-> !eeprom_data_line_oe_n_o) else $error("data out not driven");
    chk_take_busy: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        req_valid_i && req_ready_o |=> !req_ready_o) else $error("ready wrong");
    chk_ready_strap: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        !strap_valid_o |-> !req_ready_o) else $error("ready before strap");
    cov_select: cover property (@(posedge link_clk_i) disable iff (!rstn_i) $fell(rom_select_n_o));
    cov_fast: cover property (@(posedge sys_clk_i) disable iff (!rstn_i) $rose(strap_valid_o) && rom_rate_strap_o);
    cov_eeprom: cover property (@(posedge link_clk_i) disable iff (!rstn_i) eeprom_mode_i && eeprom_clock_line_o);
endmodule

bind bsp_top bsp_checker u_bsp_checker (.sys_clk_i, .rstn_i, .link_clk_i, .req_valid_i, .req_ready_o,
    .eeprom_mode_i, .suspend_i, .power_down_i, .port_enable_i, .rom_rate_strap_o, .strap_valid_o,
    .rom_select_n_o, .eeprom_clock_line_o, .eeprom_clock_line_oe_n_o, .eeprom_data_line_o,
    .eeprom_data_line_oe_n_o, .eeprom_data_line_pd_en_o);

// ===== tb/bsp_rom_model.sv
// Purpose: serial ROM and data pad model at the far side of the port
// Assumes: mode 0 flash that streams rom_byte_i again for every byte of a select window
// Notes: a released pad reads the strap pull-up, else the enabled pull-down, else the inverse of its last value
`timescale 1ns/100ps
module bsp_rom_model (
    input wire logic select_n_i,
    input wire logic sclk_i,
    input wire logic sdo_i,
    input wire logic sdo_oe_n_i,
    input wire logic pd_en_i,
    input wire logic strap_pu_i,
    input wire logic [7:0] rom_byte_i,
    output logic sdi_o,
    output logic pad_o
);
    logic [2:0] bit_idx = 3'h0;
    logic pad_last = 1'b0;
    // launch on the falling edge so the bit is settled at the rising sample
    always @(negedge sclk_i or posedge select_n_i)
    begin
        if (select_n_i)
            bit_idx <= 3'h0;
        else
            bit_idx <= bit_idx + 3'h1;
    end
    assign sdi_o = select_n_i ? ~rom_byte_i[0] : rom_byte_i[3'h7 - bit_idx];
    always @(posedge sdo_oe_n_i) pad_last <= sdo_i;
    // strap pull-up outweighs the weak internal pull-down
    always_comb
    begin
        if (!sdo_oe_n_i)
            pad_o = sdo_i;
        else if (strap_pu_i)
            pad_o = 1'b1;
        else if (pd_en_i)
            pad_o = 1'b0;
        else
            pad_o = ~pad_last;
    end
endmodule

// ===== tb/testbench.sv
// Purpose: self-checking bench of the boot ROM serial port
// Assumes: 10 ns core clock, 12 ns link clock of unrelated phase
// Notes: one task per scenario, each judged before it returns
`timescale 1ns/100ps
module testbench;
    import bsp_pkg::*;
    logic sys_clk_i = 1'b0;
    logic link_clk_i = 1'b0;
    // starts high so the first reset is a real falling edge
    logic rstn_i = 1'b1;
    logic req_valid_i = 1'b0;
    bsp_req_s req_i = '0;
    logic eeprom_mode_i = 1'b0;
    logic suspend_i = 1'b0;
    logic power_down_i = 1'b0;
    logic port_enable_i = 1'b1;
    logic strap_pu = 1'b0;
    logic [7:0] rom_byte = 8'ha5;
    logic req_ready_o, rsp_valid_o, strap, sv, sel_n, sclk, sdo, sdo_oe_n, pd_en, pad, sdi;
    bsp_rsp_s rsp_o;
    logic [8:0] sh = '0;
    logic [8:0] per_cyc = '0;
    logic [8:0] n_rise = '0;
    logic start_seen = 1'b0;
    logic sel_seen = 1'b0;
    realtime t_rise = 0.0;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;

    always #5 sys_clk_i = ~sys_clk_i;
    initial
    begin
        #3.7;
        forever #6 link_clk_i = ~link_clk_i;
    end

    bsp_top dut (.sys_clk_i, .rstn_i, .link_clk_i, .req_valid_i, .req_i, .req_ready_o, .rsp_valid_o, .rsp_o,
        .eeprom_mode_i, .suspend_i, .power_down_i, .port_enable_i, .rom_rate_strap_o(strap), .strap_valid_o(sv),
        .rom_select_n_o(sel_n), .eeprom_clock_line_o(sclk), .eeprom_clock_line_oe_n_o(),
        .eeprom_data_line_o(sdo), .eeprom_data_line_oe_n_o(sdo_oe_n), .eeprom_data_line_pd_en_o(pd_en),
        .eeprom_data_line_i(pad), .rom_data_in_i(sdi));
    bsp_rom_model rom (.select_n_i(sel_n), .sclk_i(sclk), .sdo_i(sdo), .sdo_oe_n_i(sdo_oe_n), .pd_en_i(pd_en),
        .strap_pu_i(strap_pu), .rom_byte_i(rom_byte), .sdi_o(sdi), .pad_o(pad));

    // ****************************************
    // pin monitors and helpers
    // ****************************************
    always @(posedge sclk)
    begin
        per_cyc = 9'($rtoi(($realtime - t_rise) / 12.0 + 0.5));
        t_rise = $realtime;
        sh = {sh[7:0], pad};
        n_rise++;
    end
    always @(negedge pad) if (sclk === 1'b1) start_seen = 1'b1;
    always @(negedge sel_n) sel_seen = 1'b1;
    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            summarize;
        end
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // ready is read at the edge, so it is the value the design sampled
    task automatic send(input bsp_cmd_e cmd, input logic [7:0] d);
        int k;
        k = 0;
        req_valid_i <= 1'b1;
        req_i <= '{cmd: cmd, data: d};
        do @(posedge sys_clk_i); while (req_ready_o !== 1'b1 && ++k < 50);
        req_valid_i <= 1'b0;
        do @(posedge sys_clk_i); while (rsp_valid_o !== 1'b1 && ++k < 400);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic do_reset(input logic pu);
        int k;
        k = 0;
        strap_pu <= pu;
        rstn_i <= 1'b0;
        repeat (BSP_RESET_MIN_CYC + 2) @(posedge sys_clk_i);
        chk({sclk, sdo_oe_n, pd_en, sel_n}, 4'h7);
        rstn_i <= 1'b1;
        do @(posedge sys_clk_i); while (sv !== 1'b1 && ++k < 40);
        chk(strap, pu);
        repeat (10) @(posedge sys_clk_i);
        chk({pd_en, sdo_oe_n}, 2'h0);
    endtask
    task automatic t_spi_byte(input int half);
        sel_seen = 1'b0;
        send(BSP_CMD_BYTE, 8'h3c);
        chk(sh[7:0], 8'h3c);
        chk(rsp_o.data, rom_byte);
        chk(sel_seen, 1'b1);
        chk(per_cyc, 9'(2 * half));
        rom_byte <= 8'h5a;
        send(BSP_CMD_BYTE, 8'hc3);
        chk(sh[7:0], 8'hc3);
        chk(rsp_o.data, 8'h5a);
        rom_byte <= 8'ha5;
        send(BSP_CMD_DESELECT, 8'h00);
        repeat (4) @(posedge sys_clk_i);
        chk(sel_n, 1'b1);
        n_rise = '0;
        send(BSP_CMD_START, 8'h00);
        send(BSP_CMD_STOP, 8'h00);
        chk(n_rise, 9'h000);
    endtask
    task automatic t_suspend;
        suspend_i <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
        if (strap_pu)
            chk(sdo_oe_n, 1'b1);
        else
            chk({sdo_oe_n, sdo}, 2'h0);
        suspend_i <= 1'b0;
        repeat (8) @(posedge sys_clk_i);
        chk(sdo_oe_n, 1'b0);
    endtask
    // pad floats in suspend with strap 1, so the strap level really moves
    task automatic t_strap_hold;
        suspend_i <= 1'b1;
        strap_pu <= 1'b0;
        repeat (10) @(posedge sys_clk_i);
        chk(strap, 1'b1);
        strap_pu <= 1'b1;
        suspend_i <= 1'b0;
        repeat (8) @(posedge sys_clk_i);
    endtask
    task automatic t_power_down;
        power_down_i <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
        sel_seen = 1'b0;
        send(BSP_CMD_BYTE, 8'h11);
        chk({sel_seen, sel_n}, 2'h1);
        power_down_i <= 1'b0;
        repeat (8) @(posedge sys_clk_i);
    endtask
    task automatic t_eeprom;
        eeprom_mode_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        start_seen = 1'b0;
        send(BSP_CMD_START, 8'h00);
        chk(start_seen, 1'b1);
        n_rise = '0;
        send(BSP_CMD_BYTE, 8'h96);
        chk(sh, {8'h96, 1'b1});
        chk(n_rise, 9'h009);
        chk(rsp_o.ack_n, 1'b1);
        send(BSP_CMD_STOP, 8'h00);
        eeprom_mode_i <= 1'b0;
    endtask

    initial
    begin
        do_reset(1'b0);
        t_spi_byte(BSP_HALF_SLOW);
        t_suspend;
        t_power_down;
        do_reset(1'b1);
        t_spi_byte(BSP_HALF_FAST);
        t_suspend;
        t_strap_hold;
        t_eeprom;
        summarize;
    end
endmodule
